// ==== hdl/spism_pkg.sv ====
package spism_pkg;
  // Printed register indexes; the bus byte address is four times the index
  localparam logic [11:0] IDX_DATA = 12'hf60;
  localparam logic [11:0] IDX_CTRL = 12'hf61;
  localparam logic [11:0] IDX_STAT = 12'hf62;
  localparam logic [11:0] IDX_MODE = 12'hf63;
  localparam logic [11:0] IDX_BRH  = 12'hf66;
  localparam logic [11:0] IDX_BRL  = 12'hf67;
  localparam int          ADDR_W   = 16;
  // Control fields
  localparam int CTL_EN   = 0;
  localparam int CTL_MM   = 1;
  localparam int CTL_POL  = 3;
  localparam int CTL_BIRQ = 5;
  localparam int CTL_STR  = 6;
  localparam int CTL_INTERRUPT_ENABLE_BIT = 7;
  // Status fields
  localparam int ST_IRQ = 7;
  localparam int ST_OVR = 6;
  localparam int ST_COL = 5;
  localparam int ST_ABT = 4;
  localparam int ST_TX  = 1;
  localparam int ST_SS  = 0;
  // Mode fields
  localparam int MD_COUNTER_READBACK_BIT = 5;
  localparam int MD_LEN  = 2;
  localparam int MD_SELECT_DIRECTION_BIT = 1;
  localparam int MD_SSV  = 0;
  localparam logic [7:0] MODE_MASK = 8'h3f;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h01;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'hff;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    SEL_NONE, SEL_DATA, SEL_CTRL, SEL_STAT, SEL_MODE, SEL_BRH, SEL_BRL
  } spism_sel_t;
  // Length code 0 means eight bits, others are the bit count itself
  function automatic logic [3:0] spism_char_bits(input logic [2:0] code);
    spism_char_bits = (code == 3'h0) ? 4'h8 : {1'b0, code};
  endfunction : spism_char_bits
endpackage : spism_pkg

// ==== hdl/spism_core_if.sv ====
`timescale 1ns/1ps
interface spism_core_if;
  logic        enable;
  logic        slave;
  logic        clkpol;
  logic [2:0]  char_code;
  logic        active;
  logic        abort_p;
  logic        done_p;
  logic        ss_level;
  logic        run;
  logic [15:0] reload;
  logic [15:0] count;
  modport core (output enable, slave, clkpol, char_code, run, reload,
                input active, abort_p, done_p, ss_level, count);
  modport mon  (input enable, slave, clkpol, char_code,
                output active, abort_p, done_p, ss_level);
  modport brg  (input run, reload, output count);
endinterface : spism_core_if

// ==== hdl/spism_brg.sv ====
`timescale 1ns/1ps
module spism_brg (
  // Clock and reset
  input logic          sys_clk,
  input logic          reset,
  input logic          ce,
  // Core side
  spism_core_if.brg    bif
);
  import spism_pkg::*;
  logic [15:0] cnt_r;

  // Counts down from the reload value and reloads on reaching one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_r <= {RATE_RST, RATE_RST};
    end else if (ce) begin
      if (!bif.run || cnt_r <= 16'h0001) begin
        cnt_r <= bif.reload;
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  assign bif.count = cnt_r;
endmodule : spism_brg

// ==== hdl/spism_slave_mon.sv ====
`timescale 1ns/1ps
module spism_slave_mon #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input logic          sys_clk,
  input logic          reset,
  input logic          ce,
  // Pins
  input logic          sck_pin,
  input logic          ss_n_pin,
  // Core side
  spism_core_if.mon    mif
);
  import spism_pkg::*;
  if (CNT_W < 4) begin : g_chk
    $error("CNT_W must hold a count of eight");
  end
  logic             ss_s1, ss_s2, ss_s3;
  logic             sck_s1, sck_s2, sck_s3;
  logic [CNT_W-1:0] cnt_r;
  logic             act_r, abort_r, done_r;
  logic             en_slv, sel, lead, last;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ss_s1  <= 1'b1;
      ss_s2  <= 1'b1;
      ss_s3  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
    end else if (ce) begin
      ss_s1  <= ss_n_pin;
      ss_s2  <= ss_s1;
      ss_s3  <= ss_s2;
      sck_s1 <= sck_pin;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  assign en_slv = mif.enable & mif.slave;
  assign sel    = ~ss_s2;
  // Leading edge: clock leaves its idle level
  assign lead   = (sck_s2 ^ mif.clkpol) & ~(sck_s3 ^ mif.clkpol);
  assign last   = (cnt_r + CNT_W'(1)) == CNT_W'(spism_char_bits(mif.char_code));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_r   <= '0;
      act_r   <= 1'b0;
      abort_r <= 1'b0;
      done_r  <= 1'b0;
    end else if (ce) begin
      act_r   <= en_slv & sel;
      done_r  <= en_slv & sel & lead & last;
      abort_r <= en_slv & ss_s2 & ~ss_s3 & (cnt_r != '0);
      if (!en_slv || !sel || (lead && last)) begin
        cnt_r <= '0;
      end else if (lead) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  assign mif.active   = act_r;
  assign mif.abort_p  = abort_r;
  assign mif.done_p   = done_r;
  assign mif.ss_level = ss_s2;

  a_abort_cause: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en_slv && ss_s2 && !ss_s3 && cnt_r != '0) |=> abort_r)
    else $error("slave abort not flagged on early deselect");
endmodule : spism_slave_mon

// ==== hdl/spism_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - While the unit is disabled every status bit holds its reset value.
// - Enabled unit sets interrupt pending on force bit or completed transaction.
// - Disabled unit used as baud timer never sets interrupt pending.
// - Interrupt, overrun, collision, abort flags readable; writing one clears them.
// - Overrun flag sets once an overrun is detected, else stays clear.
// - Collision flag sets when a multimaster mode fault is detected.
// - Slave deselected mid-character before all bits moved sets the abort flag.
// - A slave abort also sets interrupt pending as a completed transaction.
// - Transmit bit reads one while a transfer is in progress.
// - Select level bit mirrors the select input in slave mode.
// - Counter readback set makes rate byte reads return live counter bytes.
// - Live counter bytes are not latched together.
// - Length code zero is eight bits, others give one to seven bits.
// - Select direction bit makes select pin input or master-mode output.
// - Master-mode output select pin is driven to the drive value bit.
// - Writing one to interrupt pending also clears the force bit.
// - Data write during a transfer is dropped and sets overrun.
// - Pending interrupt reaches the output only with interrupt enable set.
module spism_regs (
  // Clock, reset, enable
  input  logic                        sys_clk,
  input  logic                        reset,
  input  logic                        ce,
  // AXI4-Lite write
  input  logic [spism_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  logic                        s_axi_awvalid,
  output logic                        s_axi_awready,
  input  logic [31:0]                 s_axi_wdata,
  input  logic [3:0]                  s_axi_wstrb,
  input  logic                        s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  logic                        s_axi_bready,
  // AXI4-Lite read
  input  logic [spism_pkg::ADDR_W-1:0] s_axi_araddr,
  input  logic                        s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  logic                        s_axi_rready,
  // Shifter side
  input  logic                        xfer_active,
  input  logic                        xfer_done,
  input  logic                        mode_fault,
  input  logic [7:0]                  shift_data,
  output logic                        data_load,
  output logic [7:0]                  data_byte,
  output logic [7:0]                  ctrl_cfg,
  output logic [2:0]                  char_code,
  // Pins
  input  logic                        sck_pin,
  input  logic                        ss_n_pin,
  output logic                        ss_n_out,
  output logic                        ss_n_oe,
  output logic                        irq_out
);
  import spism_pkg::*;

  function automatic spism_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      {2'h0, IDX_DATA, 2'h0}: reg_sel = SEL_DATA;
      {2'h0, IDX_CTRL, 2'h0}: reg_sel = SEL_CTRL;
      {2'h0, IDX_STAT, 2'h0}: reg_sel = SEL_STAT;
      {2'h0, IDX_MODE, 2'h0}: reg_sel = SEL_MODE;
      {2'h0, IDX_BRH,  2'h0}: reg_sel = SEL_BRH;
      {2'h0, IDX_BRL,  2'h0}: reg_sel = SEL_BRL;
      default:                reg_sel = SEL_NONE;
    endcase
  endfunction : reg_sel

  spism_core_if cif ();

  spism_slave_mon #(
    .CNT_W    (4)
  ) u_mon (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .sck_pin  (sck_pin),
    .ss_n_pin (ss_n_pin),
    .mif      (cif.mon)
  );

  spism_brg u_brg (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ce       (ce),
    .bif      (cif.brg)
  );

  // Register state
  logic [7:0]  ctrl_r;
  logic [7:0]  mode_r;
  logic [7:0]  brh_r;
  logic [7:0]  brl_r;
  logic        irq_r, ovr_r, col_r, abt_r, tx_r, ss_r;
  // Bus state
  logic        awr_r, arr_r, bvalid_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic        data_load_r, irq_out_r, ss_out_r, ss_oe_r;
  logic [7:0]  data_byte_r;
  // Decoded strobes
  spism_sel_t  wsel, rsel;
  logic        wr_go, rd_go, wen;
  logic        en, busy, data_wr, ovr_set, irq_set;
  logic [7:0]  clr, stat_v;

  assign en   = ctrl_r[CTL_EN];
  assign busy = xfer_active | cif.active;

  // Write address and data are taken together, one cycle after both appear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      awr_r    <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OK;
    end else if (ce) begin
      awr_r <= s_axi_awvalid & s_axi_wvalid & ~awr_r & ~bvalid_r;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wsel == SEL_NONE) ? RESP_ERR : RESP_OK;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign wr_go = awr_r & s_axi_awvalid & s_axi_wvalid;
  assign wsel  = reg_sel(s_axi_awaddr);
  assign wen   = wr_go & s_axi_wstrb[0];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      arr_r    <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OK;
      rdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      arr_r <= s_axi_arvalid & ~arr_r & ~rvalid_r;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= (rsel == SEL_NONE) ? RESP_ERR : RESP_OK;
        rdata_r  <= rdata_nxt;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign rd_go = arr_r & s_axi_arvalid;
  assign rsel  = reg_sel(s_axi_araddr);

  assign stat_v = {irq_r, ovr_r, col_r, abt_r, 2'h0, tx_r, ss_r};

  // Live counter bytes are read separately, never latched as a pair
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (rsel)
      SEL_DATA: rdata_nxt[7:0] = shift_data;
      SEL_CTRL: rdata_nxt[7:0] = ctrl_r;
      SEL_STAT: rdata_nxt[7:0] = stat_v;
      SEL_MODE: rdata_nxt[7:0] = mode_r & MODE_MASK;
      SEL_BRH:  rdata_nxt[7:0] = mode_r[MD_COUNTER_READBACK_BIT] ? cif.count[15:8] : brh_r;
      SEL_BRL:  rdata_nxt[7:0] = mode_r[MD_COUNTER_READBACK_BIT] ? cif.count[7:0] : brl_r;
      default:  rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Control, mode and rate registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
      mode_r <= MODE_RST;
      brh_r  <= RATE_RST;
      brl_r  <= RATE_RST;
    end else if (ce) begin
      if (wen && wsel == SEL_CTRL) begin
        ctrl_r <= s_axi_wdata[7:0];
      end else if (wen && wsel == SEL_STAT && s_axi_wdata[ST_IRQ]) begin
        ctrl_r[CTL_STR] <= 1'b0;
      end
      if (wen && wsel == SEL_MODE) begin
        mode_r <= s_axi_wdata[7:0] & MODE_MASK;
      end
      if (wen && wsel == SEL_BRH) begin
        brh_r <= s_axi_wdata[7:0];
      end
      if (wen && wsel == SEL_BRL) begin
        brl_r <= s_axi_wdata[7:0];
      end
    end
  end

  // Data writes go to the shifter unless a transfer is under way
  assign data_wr = wen & (wsel == SEL_DATA);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_load_r <= 1'b0;
      data_byte_r <= 8'h00;
    end else if (ce) begin
      data_load_r <= data_wr & ~busy;
      if (data_wr && !busy) begin
        data_byte_r <= s_axi_wdata[7:0];
      end
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  assign clr     = (wen && wsel == SEL_STAT) ? s_axi_wdata[7:0] : 8'h00;
  assign ovr_set = data_wr & busy;
  assign irq_set = ctrl_r[CTL_STR] | xfer_done | cif.done_p | cif.abort_p;

  always_ff @(posedge sys_clk) begin
    if (reset || (ce && !en)) begin
      irq_r <= STAT_RST[ST_IRQ];
      ovr_r <= STAT_RST[ST_OVR];
      col_r <= STAT_RST[ST_COL];
      abt_r <= STAT_RST[ST_ABT];
      tx_r  <= STAT_RST[ST_TX];
      ss_r  <= STAT_RST[ST_SS];
    end else if (ce) begin
      irq_r <= irq_set | (irq_r & ~clr[ST_IRQ]);
      ovr_r <= ovr_set | (ovr_r & ~clr[ST_OVR]);
      col_r <= mode_fault | (col_r & ~clr[ST_COL]);
      abt_r <= cif.abort_p | (abt_r & ~clr[ST_ABT]);
      tx_r  <= busy;
      ss_r  <= cif.ss_level;
    end
  end

  // Pins and interrupt output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_out_r <= 1'b0;
      ss_out_r  <= 1'b1;
      ss_oe_r   <= 1'b0;
    end else if (ce) begin
      irq_out_r <= irq_r & ctrl_r[CTL_INTERRUPT_ENABLE_BIT];
      ss_oe_r   <= en & ctrl_r[CTL_MM] & mode_r[MD_SELECT_DIRECTION_BIT];
      ss_out_r  <= mode_r[MD_SSV];
    end
  end

  // Core links
  assign cif.enable    = en;
  assign cif.slave     = ~ctrl_r[CTL_MM];
  assign cif.clkpol    = ctrl_r[CTL_POL];
  assign cif.char_code = mode_r[MD_LEN +: 3];
  assign cif.run       = en | ctrl_r[CTL_BIRQ];
  assign cif.reload    = {brh_r, brl_r};

  // Outputs
  assign s_axi_awready = awr_r;
  assign s_axi_wready  = awr_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign data_load     = data_load_r;
  assign data_byte     = data_byte_r;
  assign ctrl_cfg      = ctrl_r;
  assign char_code     = mode_r[MD_LEN +: 3];
  assign ss_n_out      = ss_out_r;
  assign ss_n_oe       = ss_oe_r;
  assign irq_out       = irq_out_r;

  a_disabled_reset: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && !en) |=> (stat_v == STAT_RST))
    else $error("status not at reset while disabled");

  a_force_irq: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en && ctrl_r[CTL_STR]) |=> irq_r)
    else $error("force bit did not raise pending interrupt");

  a_w1c_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en && clr[ST_COL] && !mode_fault) |=> !col_r)
    else $error("collision flag not cleared by write of one");

  a_overrun_set: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en && data_wr && busy) |=> (ovr_r && !data_load_r))
    else $error("busy data write not flagged as overrun");

  a_col_set: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en && mode_fault) |=> col_r)
    else $error("mode fault did not set collision");

  a_abort_irq: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en && cif.abort_p) |=> (abt_r && irq_r))
    else $error("abort did not set abort and pending");

  a_str_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && clr[ST_IRQ] && !(wen && wsel == SEL_CTRL)) |=> !ctrl_r[CTL_STR])
    else $error("force bit survived pending clear");

  a_readback_lo: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && rd_go && rsel == SEL_BRL && mode_r[MD_COUNTER_READBACK_BIT])
      |=> (s_axi_rdata[7:0] == $past(cif.count[7:0])))
    else $error("diagnostic read did not return live counter");

  a_ss_drive: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en && ctrl_r[CTL_MM] && mode_r[MD_SELECT_DIRECTION_BIT])
      |=> (ss_n_oe && ss_n_out == $past(mode_r[MD_SSV])))
    else $error("select pin not driven to drive value");

  a_irq_gate: assert property (@(posedge sys_clk) disable iff (reset)
    ce |=> (irq_out == $past(irq_r & ctrl_r[CTL_INTERRUPT_ENABLE_BIT])))
    else $error("interrupt output not gated by enable");

  a_pending_done: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en && (xfer_done || cif.done_p)) |=> irq_r)
    else $error("completed transfer did not raise pending");

  a_tx_track: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en) |=> (tx_r == $past(busy)))
    else $error("transmit bit does not follow transfer activity");

  a_sel_level: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && en) |=> (ss_r == $past(cif.ss_level)))
    else $error("select level bit does not follow select input");

  a_data_load: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && data_wr && !busy) |=> (data_load_r && data_byte_r == $past(s_axi_wdata[7:0])))
    else $error("idle data write not handed to shifter");

  a_readback_hi: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && rd_go && rsel == SEL_BRH && mode_r[MD_COUNTER_READBACK_BIT])
      |=> (s_axi_rdata[7:0] == $past(cif.count[15:8])))
    else $error("diagnostic read did not return live counter high");

  a_reload_read: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && rd_go && rsel == SEL_BRL && !mode_r[MD_COUNTER_READBACK_BIT])
      |=> (s_axi_rdata[7:0] == $past(brl_r)))
    else $error("rate low read did not return reload byte");
endmodule : spism_regs

// ==== test/spism_peer.sv ====
`timescale 1ns/1ps
module spism_peer (
  // Link pins
  output logic sck,
  output logic ss_n
);
  initial begin
    sck  = 1'b0;
    ss_n = 1'b1;
  end
  // Select level; released select sits high as the peer drives it high
  task automatic select(input logic lvl);
    #3 ss_n = lvl;
    #160;
  endtask : select
  // Clock stands at its idle level between frames; each pulse leaves it once
  task automatic pulses(input int n, input logic idle);
    #3 sck = idle;
    for (int i = 0; i < n; i++) begin
      #80 sck = ~idle;
      #80 sck = idle;
    end
  endtask : pulses
endmodule : spism_peer

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import spism_pkg::*;
  logic        sys_clk, reset, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        xfer_active, xfer_done, mode_fault, data_load, ss_n_out, ss_n_oe;
  logic        irq_out, sck, peer_ss_n, ss_n_wire;
  logic [7:0]  shift_data, data_byte, ctrl_cfg, rd, first;
  logic [2:0]  char_code, code;
  int          n_fail, n_compared, bits;
  int          n_loads = 0;

  // Select pin level from both parties; the design wins while it drives
  assign ss_n_wire = (ss_n_oe === 1'b1) ? ss_n_out : peer_ss_n;

  spism_regs i_spism_regs (
    .sys_clk(sys_clk), .reset(reset), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .xfer_active(xfer_active), .xfer_done(xfer_done), .mode_fault(mode_fault),
    .shift_data(shift_data), .data_load(data_load), .data_byte(data_byte),
    .ctrl_cfg(ctrl_cfg), .char_code(char_code), .sck_pin(sck), .ss_n_pin(ss_n_wire),
    .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .irq_out(irq_out)
  );
  spism_peer i_spism_peer (.sck(sck), .ss_n(peer_ss_n));

  // Accepted data writes, counted at the edge that sees the load pulse
  always @(posedge sys_clk) begin
    if (data_load === 1'b1) n_loads++;
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] ba(input logic [11:0] idx);
    ba = {2'b00, idx, 2'b00};
  endfunction : ba

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st = 4'hf);
    int t;
    t = 0;
    awaddr  <= ba(idx);
    wdata   <= {24'h0, d};
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 100);
    resp = bresp;
    if (t >= 100) check(8'h00, 8'h01, "write stall");
  endtask : wr

  task automatic rd_reg(input logic [11:0] idx);
    int t;
    t = 0;
    araddr  <= ba(idx);
    arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 100);
    rd   = rdata[7:0];
    resp = rresp;
    if (t >= 100) check(8'h00, 8'h01, "read stall");
  endtask : rd_reg

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp, input string what);
    rd_reg(idx);
    check(rd, exp, what);
  endtask : rd_chk

  task automatic pulse(input bit fault);
    if (fault) mode_fault <= 1'b1;
    else xfer_done <= 1'b1;
    @(posedge sys_clk);
    mode_fault <= 1'b0;
    xfer_done  <= 1'b0;
    @(posedge sys_clk);
  endtask : pulse

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    #400000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    {reset, ce, bready, rready} = 4'hf;
    {awvalid, wvalid, arvalid, xfer_active, xfer_done, mode_fault} = 6'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0;
    wstrb = 4'hf;
    shift_data = 8'ha5;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd_chk(IDX_STAT, 8'h01, "status reset");
    rd_chk(IDX_MODE, 8'h00, "mode reset");
    rd_chk(IDX_CTRL, 8'h00, "control reset");
    rd_chk(IDX_BRH, 8'hff, "rate high reset");
    rd_chk(IDX_BRL, 8'hff, "rate low reset");
    rd_chk(IDX_DATA, 8'ha5, "data read");
    rd_chk(12'hf65, 8'h00, "unmapped read");
    check({6'h0, resp}, 8'h02, "unmapped read resp");
    wr(12'hf65, 8'h5a);
    check({6'h0, resp}, 8'h02, "unmapped write resp");
    wr(IDX_MODE, 8'hff);
    rd_chk(IDX_MODE, 8'h3f, "reserved mode bits");
    wr(IDX_MODE, 8'h00, 4'h0);
    rd_chk(IDX_MODE, 8'h3f, "strobe off write");
    for (int c = 0; c < 8; c++) begin
      wr(IDX_MODE, {3'h0, 3'(c), 2'b00});
      repeat (2) @(posedge sys_clk);
      check({5'h0, char_code}, {5'h0, 3'(c)}, "length code");
    end
    $display("test reset_and_map done");

    wr(IDX_CTRL, 8'h20);
    pulse(1'b0);
    pulse(1'b1);
    rd_chk(IDX_STAT, 8'h01, "disabled timer");
    wr(IDX_CTRL, 8'h03);
    pulse(1'b1);
    rd_chk(IDX_STAT, 8'h21, "collision");
    wr(IDX_CTRL, 8'h02);
    rd_chk(IDX_STAT, 8'h01, "disable resets");
    wr(IDX_CTRL, 8'h03);
    pulse(1'b0);
    pulse(1'b1);
    wr(IDX_DATA, 8'h96);
    check(data_byte, 8'h96, "idle data write");
    xfer_active <= 1'b1;
    wr(IDX_DATA, 8'h3c);
    check(data_byte, 8'h96, "busy data ignored");
    check(8'(n_loads), 8'h01, "one data load");
    rd_chk(IDX_STAT, 8'he3, "flags set");
    wr(IDX_STAT, 8'h00);
    rd_chk(IDX_STAT, 8'he3, "zero write");
    wr(IDX_STAT, 8'h70);
    rd_chk(IDX_STAT, 8'h83, "clear three");
    xfer_active <= 1'b0;
    wr(IDX_STAT, 8'h80);
    rd_chk(IDX_STAT, 8'h01, "clear pending");
    $display("test status_flags done");

    wr(IDX_CTRL, 8'h43);
    rd_chk(IDX_STAT, 8'h81, "force pending");
    check({7'h0, irq_out}, 8'h00, "irq masked");
    wr(IDX_CTRL, 8'hc3);
    repeat (2) @(posedge sys_clk);
    check({7'h0, irq_out}, 8'h01, "irq enabled");
    check(ctrl_cfg, 8'hc3, "control copy");
    wr(IDX_STAT, 8'h80);
    rd_chk(IDX_CTRL, 8'h83, "force cleared");
    wr(IDX_STAT, 8'h80);
    rd_chk(IDX_STAT, 8'h01, "pending cleared");
    check({7'h0, irq_out}, 8'h00, "irq dropped");
    ce         <= 1'b0;
    mode_fault <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ce         <= 1'b1;
    mode_fault <= 1'b0;
    rd_chk(IDX_STAT, 8'h01, "fault while frozen");
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd_chk(IDX_CTRL, 8'h00, "control after reset");
    rd_chk(IDX_MODE, 8'h00, "mode after reset");
    $display("test force_irq done");

    wr(IDX_CTRL, 8'h03);
    wr(IDX_MODE, 8'h02);
    repeat (2) @(posedge sys_clk);
    check({6'h0, ss_n_oe, ss_n_out}, 8'h02, "select drives low");
    wr(IDX_MODE, 8'h03);
    repeat (2) @(posedge sys_clk);
    check({6'h0, ss_n_oe, ss_n_out}, 8'h03, "select drives high");
    wr(IDX_CTRL, 8'h01);
    repeat (2) @(posedge sys_clk);
    check({7'h0, ss_n_oe}, 8'h00, "slave select input");
    $display("test select_pin done");

    for (int k = 0; k < 3; k++) begin
      code = (k == 0) ? 3'h0 : 3'(k + 3);
      bits = (k == 0) ? 8 : k + 3;
      wr(IDX_MODE, {3'h0, code, 2'b00});
      wr(IDX_CTRL, (k == 2) ? 8'h09 : 8'h01);
      for (int full = 0; full < 2; full++) begin
        i_spism_peer.select(1'b0);
        @(posedge sys_clk);
        rd_chk(IDX_STAT, 8'h02, "selected");
        i_spism_peer.pulses(bits - 1 + full, k == 2);
        i_spism_peer.select(1'b1);
        repeat (10) @(posedge sys_clk);
        rd_chk(IDX_STAT, (full == 1) ? 8'h81 : 8'h91, "frame end");
        wr(IDX_STAT, 8'hf0);
      end
    end
    $display("test slave_frames done");

    wr(IDX_CTRL, 8'h00);
    wr(IDX_BRH, 8'h12);
    wr(IDX_BRL, 8'h34);
    wr(IDX_MODE, 8'h20);
    rd_chk(IDX_BRH, 8'h12, "held counter high");
    rd_chk(IDX_BRL, 8'h34, "held counter low");
    wr(IDX_BRH, 8'h00);
    wr(IDX_BRL, 8'hc8);
    wr(IDX_CTRL, 8'h01);
    rd_chk(IDX_BRH, 8'h00, "live counter high");
    rd_reg(IDX_BRL);
    first = rd;
    rd_reg(IDX_BRL);
    check({7'h0, first !== rd}, 8'h01, "live counter moves");
    wr(IDX_MODE, 8'h00);
    rd_chk(IDX_BRL, 8'hc8, "reload readback");
    $display("test rate_readback done");
    complete_run();
  end
endmodule : testbench
